// *** rtl/cps_map.vh ***
// Register map, field positions, reset values and completion codes for the port status tracker.
// Assumes a 32-bit AXI4-Lite bus with byte addresses; every register is one aligned word.
//
// Behaviour
// (RL1) One available flag per logical port, bits 0-7
// (RL2) Available clear while running, set at any finish
// (RL3) Eight completion words, port 0 lowest, port 7 highest
// (RL4) Completion word zero while running, code at finish
// (RL5) All completion words zero at operation start
// (RL6) Error bit set on error, cleared on success
// (RL7) Error bit held until next launch clears it
// (RL8) Codes 0205 timeout, 0401 undefined command
// (RL9) Codes 1001 long, 1002 short, 1003 count, 1004 format
// (RL10) Codes 110C parameter, 2201 busy sending, 2202 switching
// (RL11) Raw-send executing bit 5 per serial port
// (RL12) Receive byte count accepted only 0 to 256
// (RL13) Trigger every scan or once on rising edge
// (RL14) Direct addressing: port 0, unit 80h/81h plus 4u
// (RL15) Error indication on bad count or busy port
// (RL16) Accept clears flag, zeroes code, clears error
// (RL17) Busy port refused, code and error bit untouched
`ifndef CPS_MAP_VH
`define CPS_MAP_VH

// Register byte offsets
`define CPS_OFF_AVAIL      8'h00
`define CPS_OFF_ERRFLAGS   8'h04
`define CPS_OFF_SER1_STAT  8'h08
`define CPS_OFF_SER2_STAT  8'h0c
`define CPS_OFF_LAUNCH     8'h10
`define CPS_OFF_COUNT      8'h14
`define CPS_OFF_LSTAT      8'h18
`define CPS_OFF_CODE_BASE  8'h20
`define CPS_OFF_CODE_LAST  8'h3c

// Launch control field positions
`define CPS_LC_LPORT_LSB   0
`define CPS_LC_KIND_BIT    3
`define CPS_LC_TRIG_BIT    4
`define CPS_LC_COND_BIT    5
`define CPS_LC_SPORT_LSB   8
`define CPS_LC_UNIT_LSB    16

// Serial port status word bit for raw send executing
`define CPS_TXEXEC_BIT     5

// Reset values
`define CPS_AVAIL_RST      8'hff
`define CPS_CODE_RST       16'h0000
`define CPS_LAUNCH_RST     32'h0000_0000
`define CPS_COUNT_RST      16'h0000

// Byte count limit and direct unit address base
`define CPS_COUNT_MAX      16'h0100
`define CPS_DIRECT_BASE    8'h80

// Completion codes
`define CPS_CC_OK          16'h0000
`define CPS_CC_TIMEOUT     16'h0205
`define CPS_CC_UNDEF_CMD   16'h0401
`define CPS_CC_TOO_LONG    16'h1001
`define CPS_CC_TOO_SHORT   16'h1002
`define CPS_CC_COUNT_BAD   16'h1003
`define CPS_CC_FORMAT_BAD  16'h1004
`define CPS_CC_PARAM_BAD   16'h110c
`define CPS_CC_BUSY_SEND   16'h2201
`define CPS_CC_SWITCHING   16'h2202

// AXI responses
`define CPS_RESP_OKAY      2'b00
`define CPS_RESP_SLVERR    2'b10

`endif

// *** rtl/cps_port_tracker.v ***
// Communications port status tracker: per logical port availability, completion
// codes and error flags, raw-send executing bits, and raw-receive launch checks.
// Assumes scan_tick and the serial unit completion inputs come from logic on mclk.
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
`include "cps_map.vh"

module cps_port_tracker #(
  parameter NPORT = 8
) (
  input  wire        mclk,
  input  wire        arst_n,
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Controller scan
  input  wire        scan_tick,
  // Serial communications unit side
  output reg         launch_vld,
  output reg  [2:0]  launch_lport,
  output reg         launch_recv,
  output reg         launch_sport2,
  output reg  [7:0]  launch_unit,
  output reg  [15:0] launch_count,
  input  wire        cmp_vld,
  input  wire [2:0]  cmp_lport,
  input  wire [15:0] cmp_code,
  // Status pins
  output reg  [7:0]  port_available_flag,
  output reg  [7:0]  port_error_flag_word,
  output reg  [1:0]  raw_send_executing,
  output reg         instruction_error_indication
);

  // Launch control and byte count are written by software;
  // the scan logic only ever reads them.
  // Last-attempt results are kept for the launch status word
  // so software can see why a scan did or did not launch.
  // All state here is cleared by arst_n, the operation start.
  // Software registers
  reg [31:0]         launch_q;
  reg [15:0]         count_q;
  reg                cond_prev_q;
  reg                acc_last_q;
  reg                sport2_res_q;
  reg [7:0]          unit_res_q;
  // Per-port state
  reg [15:0]         code_q [0:NPORT-1];
  reg [NPORT-1:0]    kind_send_q;
  reg [NPORT-1:0]    sport2_q;

  // Decoded launch fields
  wire [2:0]  lc_lport = launch_q[`CPS_LC_LPORT_LSB +: 3];
  wire        lc_recv  = launch_q[`CPS_LC_KIND_BIT];
  wire        lc_edge  = launch_q[`CPS_LC_TRIG_BIT];
  wire        lc_cond  = launch_q[`CPS_LC_COND_BIT];
  wire [3:0]  lc_sport = launch_q[`CPS_LC_SPORT_LSB +: 4];
  wire [7:0]  lc_unit  = launch_q[`CPS_LC_UNIT_LSB +: 8];

  // Edge form remembers the condition seen at the previous scan,
  // not the previous clock, so a condition held between scans
  // never launches twice.
  // The history resets low: a condition already true at the
  // first scan counts as a rising edge.
  // Trigger: every scan while true, or once on a rising edge
  wire fire = scan_tick & lc_cond & (~lc_edge | ~cond_prev_q);  // [RL13]

  // Direct form: unit address encodes unit number and port.
  // Bit 1 set is not a serial port address: parameter error.
  // Non-direct form takes serial port 1 or 2 only.
  // Resolved unit and port travel with the launch so the
  // serial unit never sees the raw encoding.
  // Direct unit addressing when serial port number is zero
  wire       direct    = (lc_sport == 4'h0);
  wire [7:0] dir_off   = lc_unit - `CPS_DIRECT_BASE;
  wire       dir_bad   = (lc_unit < `CPS_DIRECT_BASE) | lc_unit[1];  // [RL14]
  wire       param_bad = direct ? dir_bad : ((lc_sport != 4'h1) & (lc_sport != 4'h2));
  wire       res_s2    = direct ? lc_unit[0] : (lc_sport == 4'h2);   // [RL14]
  wire [7:0] res_unit  = direct ? {2'b00, dir_off[7:2]} : lc_unit;

  // Refusals come first: a bad count or a busy port leaves the
  // port untouched and only raises the error indication.
  // A launch that passes those checks is accepted, but may still
  // end at once with a code of its own: bad addressing or a send
  // to a serial port whose raw send is still running.
  // Count limit applies to receives only.
  // Launch checks
  wire range_bad = lc_recv & (count_q > `CPS_COUNT_MAX);        // [RL12]
  wire port_busy = ~port_available_flag[lc_lport];
  wire er_now    = fire & (range_bad | port_busy);               // [RL15]
  wire acc       = fire & ~er_now;                               // [RL17]
  wire tx_busy   = ~lc_recv & raw_send_executing[res_s2];
  wire [15:0] imm_code = param_bad ? `CPS_CC_PARAM_BAD :
                         (tx_busy ? `CPS_CC_BUSY_SEND : `CPS_CC_OK);  // [RL10]
  wire acc_run   = acc & (imm_code == `CPS_CC_OK);
  wire acc_fail  = acc & (imm_code != `CPS_CC_OK);
  wire cmp_take  = cmp_vld & ~port_available_flag[cmp_lport];

  // Indication and last-attempt fields change only on a fired
  // scan, so software reads a stable result between scans.
  // Launch fields stand until the next launch that passes every check.
  // The launch pulse lasts one cycle and follows the scan.
  // Scan-side bookkeeping and launch pulse to the serial unit
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cond_prev_q                  <= 1'b0;
      instruction_error_indication <= 1'b0;
      acc_last_q                   <= 1'b0;
      sport2_res_q                 <= 1'b0;
      unit_res_q                   <= 8'h00;
      launch_vld                   <= 1'b0;
      launch_lport                 <= 3'h0;
      launch_recv                  <= 1'b0;
      launch_sport2                <= 1'b0;
      launch_unit                  <= 8'h00;
      launch_count                 <= 16'h0000;
    end else begin
      launch_vld <= acc_run;
      if (scan_tick) begin
        cond_prev_q <= lc_cond;
      end
      if (fire) begin
        instruction_error_indication <= er_now;              // [RL15]
        acc_last_q                   <= acc;
        sport2_res_q                 <= res_s2;
        unit_res_q                   <= res_unit;
      end
      if (acc_run) begin
        launch_lport  <= lc_lport;
        launch_recv   <= lc_recv;
        launch_sport2 <= res_s2;
        launch_unit   <= res_unit;
        launch_count  <= count_q;
      end
    end
  end

  // Accept needs the flag set and completion needs it clear,
  // so one port never sees both in the same cycle.
  // A completion for a free port is stray and ignored, which
  // keeps a late answer from overwriting a fresh result.
  // Kind and serial port are kept per port so the completion
  // knows which raw send flag to drop.
  // Immediate failures keep the port free.
  // Per logical port availability, completion code and error bit
  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi = gi + 1) begin : g_port
      wire sel_acc = acc & (lc_lport == gi);
      wire sel_cmp = cmp_take & (cmp_lport == gi);
      always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          port_available_flag[gi]  <= 1'b1;
          port_error_flag_word[gi] <= 1'b0;
          code_q[gi]               <= `CPS_CODE_RST;    // [RL5]
          kind_send_q[gi]          <= 1'b0;
          sport2_q[gi]             <= 1'b0;
        end else if (sel_acc) begin
          kind_send_q[gi] <= ~lc_recv;
          sport2_q[gi]    <= res_s2;
          if (imm_code == `CPS_CC_OK) begin
            port_available_flag[gi]  <= 1'b0;           // [RL16] [RL2]
            code_q[gi]               <= `CPS_CC_OK;     // [RL16] [RL4]
            port_error_flag_word[gi] <= 1'b0;           // [RL16] [RL7]
          end else begin
            code_q[gi]               <= imm_code;       // Ends at once with error
            port_error_flag_word[gi] <= 1'b1;           // [RL6]
          end
        end else if (sel_cmp) begin
          port_available_flag[gi]  <= 1'b1;                         // [RL2]
          code_q[gi]               <= cmp_code;                     // [RL4] [RL8] [RL9]
          port_error_flag_word[gi] <= (cmp_code != `CPS_CC_OK);     // [RL6]
        end
      end
    end
  endgenerate

  // Set wins over clear: a new send accepted in the cycle an
  // old one completes leaves the flag high.
  // A send refused for a busy serial port never sets it.
  // Completion of a receive leaves both flags alone.
  // Raw send executing bit per serial port
  genvar gs;
  generate
    for (gs = 0; gs < 2; gs = gs + 1) begin : g_ser
      wire set_x = acc_run & ~lc_recv & (res_s2 == gs);
      wire clr_x = cmp_take & kind_send_q[cmp_lport] & (sport2_q[cmp_lport] == gs);
      always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          raw_send_executing[gs] <= 1'b0;
        end else if (set_x) begin
          raw_send_executing[gs] <= 1'b1;               // [RL11]
        end else if (clr_x) begin
          raw_send_executing[gs] <= 1'b0;               // [RL11]
        end
      end
    end
  endgenerate

  // Readies are registered and pulse every other idle cycle,
  // which keeps each output a flip-flop at the cost of one
  // extra cycle per request.
  // A channel already held keeps its ready low until the
  // response is taken, so one write at a time is under way.
  // AXI write: address and data taken in either order, response after both
  reg        aw_held_q;
  reg        w_held_q;
  reg [7:0]  aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;
  wire       aw_take = s_axi_awvalid & s_axi_awready;
  wire       w_take  = s_axi_wvalid & s_axi_wready;
  wire       have_aw = aw_held_q | aw_take;
  wire       have_w  = w_held_q | w_take;
  wire [7:0] wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_held_q ? w_data_q : s_axi_wdata;
  wire [3:0]  wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
  wire       wr_do   = have_aw & have_w & ~s_axi_bvalid;
  wire       wr_hit  = (wr_addr == `CPS_OFF_LAUNCH) | (wr_addr == `CPS_OFF_COUNT);

  // Only the lanes with their strobe set replace stored bytes.
  // Byte count takes lanes 0 and 1 only; upper lanes are ignored.
  // Merge byte lanes into the launch control register
  reg [31:0] launch_d;
  integer    bi;
  always @* begin
    launch_d = launch_q;
    for (bi = 0; bi < 4; bi = bi + 1) begin
      if (wr_strb[bi]) begin
        launch_d[bi*8 +: 8] = wr_data[bi*8 +: 8];
      end
    end
  end

  // Write channel handshake and register update
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CPS_RESP_OKAY;
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      launch_q      <= `CPS_LAUNCH_RST;
      count_q       <= `CPS_COUNT_RST;
    end else begin
      s_axi_awready <= ~have_aw & ~s_axi_bvalid & ~s_axi_awready;
      s_axi_wready  <= ~have_w & ~s_axi_bvalid & ~s_axi_wready;
      if (aw_take & ~wr_do) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take & ~wr_do) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `CPS_RESP_OKAY : `CPS_RESP_SLVERR;
        if (wr_addr == `CPS_OFF_LAUNCH) begin
          launch_q <= launch_d;
        end
        if (wr_addr == `CPS_OFF_COUNT) begin
          if (wr_strb[0]) count_q[7:0]  <= wr_data[7:0];
          if (wr_strb[1]) count_q[15:8] <= wr_data[15:8];
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data is decoded from the live address and captured at
  // the address handshake; unmapped words read zero with an
  // error response.
  // Read data selection
  reg [31:0] rd_d;
  reg        rd_ok;
  always @* begin
    rd_d  = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `CPS_OFF_AVAIL:     rd_d = {24'h000000, port_available_flag};          // [RL1]
      `CPS_OFF_ERRFLAGS:  rd_d = {24'h000000, port_error_flag_word};         // [RL6]
      `CPS_OFF_SER1_STAT: rd_d = {26'h0, raw_send_executing[0], 5'h00};      // [RL11]
      `CPS_OFF_SER2_STAT: rd_d = {26'h0, raw_send_executing[1], 5'h00};      // [RL11]
      `CPS_OFF_LAUNCH:    rd_d = launch_q;
      `CPS_OFF_COUNT:     rd_d = {16'h0000, count_q};
      `CPS_OFF_LSTAT:     rd_d = {16'h0000, unit_res_q, 5'h00, sport2_res_q,
                                  acc_last_q, instruction_error_indication};
      default: begin
        if ((s_axi_araddr >= `CPS_OFF_CODE_BASE) && (s_axi_araddr <= `CPS_OFF_CODE_LAST) &&
            (s_axi_araddr[1:0] == 2'b00)) begin
          rd_d = {16'h0000, code_q[s_axi_araddr[4:2]]};                     // [RL3]
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  // Ready drops while data waits, so one read at a time.
  // Read data stands unchanged until rready is seen.
  // Address ready resets low and rises at the first edge.
  // Read channel: one cycle from address to data
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CPS_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_d;
        s_axi_rresp  <= rd_ok ? `CPS_RESP_OKAY : `CPS_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// *** bench/cps_port_monitor.sv ***
// Checker for the port status tracker, bound to its top ports.
// Assumes the single mclk domain with active-low arst_n.
`timescale 1ns/10ps
module cps_port_monitor (
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic        scan_tick,
  input wire logic        cmp_vld,
  input wire logic [2:0]  cmp_lport,
  input wire logic [15:0] cmp_code,
  input wire logic        launch_vld,
  input wire logic [2:0]  launch_lport,
  input wire logic        launch_recv,
  input wire logic        launch_sport2,
  input wire logic [7:0]  port_available_flag,
  input wire logic [7:0]  port_error_flag_word,
  input wire logic [1:0]  raw_send_executing,
  input wire logic        instruction_error_indication,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Effects of launch and completion on the port flags, and the write response hold
  a_launch_busy: assert property (launch_vld |-> !port_available_flag[launch_lport])
    else $error("launched port still free");
  a_launch_clean: assert property (launch_vld |-> !port_error_flag_word[launch_lport])
    else $error("launched port keeps error");
  a_launch_scan: assert property (launch_vld |-> $past(scan_tick))
    else $error("launch without scan");
  a_cmp_free: assert property (cmp_vld && !port_available_flag[cmp_lport] |=>
    port_available_flag[$past(cmp_lport)]) else $error("port not freed");
  a_cmp_err: assert property (cmp_vld && !port_available_flag[cmp_lport] |=>
    port_error_flag_word[$past(cmp_lport)] == ($past(cmp_code) != 16'h0000)) else $error("error bit wrong");
  a_err_hold: assert property (!$stable(port_error_flag_word) |-> $past(scan_tick) || $past(cmp_vld))
    else $error("error bits moved");
  a_avail_drop: assert property (!$past(scan_tick) |->
    (~port_available_flag & $past(port_available_flag)) == 8'h00) else $error("flag cleared off scan");
  a_send_exec: assert property (launch_vld && !launch_recv |-> raw_send_executing[launch_sport2])
    else $error("send bit not set");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  // Main scenarios
  c_recv: cover property (launch_vld && launch_recv);
  c_fail: cover property (cmp_vld && cmp_code != 16'h0000);
  c_refuse: cover property ($rose(instruction_error_indication));
endmodule

// *** bench/cps_unit_model.sv ***
// Serial unit model: answers each launch after a set delay with a set code.
// Assumes the bench picks delays so that no two answers fall due together.
`timescale 1ns/10ps
module cps_unit_model (
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic        launch_vld,
  input wire logic [2:0]  launch_lport,
  input wire logic [15:0] rsp_code,
  input wire logic [7:0]  rsp_delay,
  output logic            cmp_vld,
  output logic [2:0]      cmp_lport,
  output logic [15:0]     cmp_code
);
  logic [7:0]  due_q [8];
  logic [15:0] code_q [8];
  // Count down each open port, report once, show junk when idle
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cmp_vld <= 1'b0;
      cmp_lport <= 3'h0;
      cmp_code <= 16'h0000;
      for (int i = 0; i < 8; i++) due_q[i] <= 8'h00;
    end else begin
      cmp_vld <= 1'b0;
      cmp_lport <= ~cmp_lport;
      cmp_code <= ~cmp_code;
      for (int i = 0; i < 8; i++) begin
        if (due_q[i] == 8'h01) begin
          cmp_vld <= 1'b1;
          cmp_lport <= 3'(i);
          cmp_code <= code_q[i];
        end
        if (due_q[i] != 8'h00) due_q[i] <= due_q[i] - 8'h01;
      end
      if (launch_vld) begin
        due_q[launch_lport] <= rsp_delay;
        code_q[launch_lport] <= rsp_code;
      end
    end
  end
endmodule

// *** bench/cps_port_tracker_tb.sv ***
// Bench for the port status tracker: AXI4-Lite tasks, scan pulses, unit model.
// Assumes the register map header and the design are compiled first.
`timescale 1ns/10ps
`include "cps_map.vh"
module cps_port_tracker_tb;
  logic        mclk, arst_n, scan_tick, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        cmp_vld, launch_vld, launch_recv, launch_sport2, instruction_error_indication;
  logic [1:0]  s_axi_bresp, s_axi_rresp, raw_send_executing;
  logic [2:0]  launch_lport, cmp_lport;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, launch_unit, port_available_flag, port_error_flag_word, rsp_delay;
  logic [15:0] launch_count, cmp_code, rsp_code;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
  logic [15:0] codes [8] = '{16'h0000, `CPS_CC_TIMEOUT, `CPS_CC_UNDEF_CMD, `CPS_CC_TOO_LONG,
                             `CPS_CC_TOO_SHORT, `CPS_CC_COUNT_BAD, `CPS_CC_FORMAT_BAD, `CPS_CC_SWITCHING};
  int          mismatches, comparisons, nlaunch, n0;
  cps_port_tracker #(.NPORT(8)) i_cps_port_tracker (.mclk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .scan_tick, .launch_vld, .launch_lport, .launch_recv, .launch_sport2, .launch_unit,
    .launch_count, .cmp_vld, .cmp_lport, .cmp_code, .port_available_flag, .port_error_flag_word,
    .raw_send_executing, .instruction_error_indication);
  cps_unit_model i_cps_unit_model (.mclk, .arst_n, .launch_vld, .launch_lport, .rsp_code, .rsp_delay,
    .cmp_vld, .cmp_lport, .cmp_code);
  // Clock, launch counter and watchdog
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) if (launch_vld === 1'b1) nlaunch++;
  initial begin
    #100000;
    mismatches++;
    give_verdict;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Bus master tasks: hold each channel until its ready, then the answer
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, w, b;
    @(posedge mclk);
    {aw, w, b} = 3'b000;
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (!b) begin
      @(posedge mclk);
      if (!aw && s_axi_awready === 1'b1) {aw, s_axi_awvalid} <= 2'b10;
      if (!w && s_axi_wready === 1'b1) {w, s_axi_wvalid} <= 2'b10;
      if (s_axi_bvalid === 1'b1) begin
        b = 1'b1;
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, r});
      end
    end
  endtask
  task rd(input logic [7:0] a, input logic [1:0] r);
    logic ar, dn;
    @(posedge mclk);
    {ar, dn} = 2'b00;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    while (!dn) begin
      @(posedge mclk);
      if (!ar && s_axi_arready === 1'b1) {ar, s_axi_arvalid} <= 2'b10;
      if (s_axi_rvalid === 1'b1) begin
        {dn, rd_q} = {1'b1, s_axi_rdata};
        s_axi_rready <= 1'b0;
        chk({30'h0, s_axi_rresp}, {30'h0, r});
      end
    end
  endtask
  task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a, `CPS_RESP_OKAY);
    chk(rd_q & m, e);
  endtask
  // Program launch control and count, then pulse one scan
  task go(input logic [31:0] c, input logic [15:0] n, input logic [15:0] code, input logic [7:0] dl);
    wr(`CPS_OFF_LAUNCH, c, `CPS_RESP_OKAY);
    {rsp_code, rsp_delay} <= {code, dl};
    wr(`CPS_OFF_COUNT, {16'h0, n}, `CPS_RESP_OKAY);
    @(posedge mclk);
    scan_tick <= 1'b1;
    @(posedge mclk);
    scan_tick <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  function automatic logic [31:0] cw(input int lp, input logic rv, ed, input logic [3:0] sp, input logic [7:0] ua);
    return {8'h00, ua, 4'h0, sp, 3'b001, ed, rv, 3'(lp)};
  endfunction
  function automatic logic [7:0] ca(input int p);
    return `CPS_OFF_CODE_BASE + 8'(p * 4);
  endfunction
  // Reset, then the scenarios in order
  initial begin
    {scan_tick, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, arst_n} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rsp_code, rsp_delay} = '0;
    s_axi_wstrb = 4'hf;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    rc(`CPS_OFF_AVAIL, 32'hff, 32'hff);
    rc(`CPS_OFF_ERRFLAGS, 32'hff, 32'h0);
    for (int i = 0; i < 8; i++) rc(ca(i), 32'hffff, 32'h0);
    rd(8'h40, `CPS_RESP_SLVERR);
    chk(rd_q, 32'h0);
    wr(8'h44, 32'h1, `CPS_RESP_SLVERR);
    // Each port in turn ends with one unit completion code
    for (int i = 0; i < 8; i++) begin
      go(cw(i, 1'b1, 1'b0, 4'h1, 8'h02), 16'h0010, codes[i], 8'd12);
      rc(`CPS_OFF_AVAIL, 32'hff, 32'hff & ~(32'h1 << i));
      rc(ca(i), 32'hffff, 32'h0);
      repeat (12) @(posedge mclk);
      rc(`CPS_OFF_AVAIL, 32'hff, 32'hff);
      rc(ca(i), 32'hffff, {16'h0, codes[i]});
    end
    rc(`CPS_OFF_ERRFLAGS, 32'hff, 32'hfe);
    // Relaunch clears error; busy port and count over range refused
    go(cw(1, 1'b1, 1'b0, 4'h1, 8'h02), 16'h0100, 16'h0, 8'd40);
    chk({16'h0, launch_count}, 32'h100);
    chk({29'h0, launch_lport}, 32'h1);
    rc(`CPS_OFF_ERRFLAGS, 32'hff, 32'hfc);
    rc(`CPS_OFF_LSTAT, 32'h1, 32'h0);
    go(cw(1, 1'b0, 1'b0, 4'h1, 8'h02), 16'h0, 16'h1234, 8'd3);
    rc(`CPS_OFF_LSTAT, 32'h1, 32'h1);
    rc(ca(1), 32'hffff, 32'h0);
    rc(`CPS_OFF_ERRFLAGS, 32'h02, 32'h0);
    go(cw(2, 1'b1, 1'b0, 4'h1, 8'h02), 16'h0101, 16'h0, 8'd40);
    rc(`CPS_OFF_LSTAT, 32'h1, 32'h1);
    rc(`CPS_OFF_AVAIL, 32'h04, 32'h04);
    repeat (40) @(posedge mclk);
    // Raw send busy flag, then a second send to that serial port
    go(cw(3, 1'b0, 1'b0, 4'h1, 8'h02), 16'h0, 16'h0, 8'd40);
    rc(`CPS_OFF_SER1_STAT, 32'h20, 32'h20);
    go(cw(0, 1'b0, 1'b0, 4'h1, 8'h02), 16'h0, 16'h0, 8'd3);
    rc(ca(0), 32'hffff, {16'h0, `CPS_CC_BUSY_SEND});
    rc(`CPS_OFF_ERRFLAGS, 32'h01, 32'h01);
    repeat (40) @(posedge mclk);
    rc(`CPS_OFF_SER1_STAT, 32'h20, 32'h0);
    // Direct unit address for serial port 2 of unit 2, then a bad address
    go(cw(5, 1'b0, 1'b0, 4'h0, 8'h89), 16'h0, 16'h0, 8'd20);
    chk({31'h0, launch_sport2}, 32'h1);
    chk({24'h0, launch_unit}, 32'h2);
    rc(`CPS_OFF_SER2_STAT, 32'h20, 32'h20);
    go(cw(6, 1'b1, 1'b0, 4'h0, 8'h12), 16'h0, 16'h0, 8'd3);
    rc(ca(6), 32'hffff, {16'h0, `CPS_CC_PARAM_BAD});
    go(cw(4, 1'b1, 1'b0, 4'h3, 8'h02), 16'h0, 16'h0, 8'd3);
    rc(ca(4), 32'hffff, {16'h0, `CPS_CC_PARAM_BAD});
    repeat (20) @(posedge mclk);
    // Edge form fires only on a rising condition
    n0 = nlaunch;
    go(cw(7, 1'b1, 1'b1, 4'h1, 8'h02) & 32'hffffffdf, 16'h0, 16'h0, 8'd2);
    go(cw(7, 1'b1, 1'b1, 4'h1, 8'h02), 16'h0, 16'h0, 8'd2);
    go(cw(7, 1'b1, 1'b1, 4'h1, 8'h02), 16'h0, 16'h0, 8'd2);
    chk(nlaunch - n0, 32'h1);
    give_verdict;
  end
endmodule
bind cps_port_tracker cps_port_monitor i_cps_port_monitor (.mclk, .arst_n, .scan_tick, .cmp_vld, .cmp_lport,
  .cmp_code, .launch_vld, .launch_lport, .launch_recv, .launch_sport2, .port_available_flag,
  .port_error_flag_word, .raw_send_executing, .instruction_error_indication, .s_axi_bvalid, .s_axi_bready);
